// >>> verilog/modbus_bank_pkg.sv
// constants and types shared by both ends of the modbus register bank link
// Function
// [RULE1] only function codes 3, 6, 16 used
// [RULE2] block read returns contiguous registers from start
// [RULE3] single write stores one word at address
// [RULE4] block write fills consecutive registers from start
// [RULE5] host strips 40000 offset, implies read
// [RULE6] serve only in modbus mode, valid id
// [RULE7] input n result at register n
// [RULE8] output n result at register 500+n
// [RULE9] sixteen writable alias table source addresses
// [RULE10] window entry n reads table n source
// [RULE11] window block read follows alias table order
// [RULE12] window write forwards to aliased source register
package modbus_bank_pkg;

  // ==========================================================
  // function codes and exception answers
  localparam logic [7:0] FUNC_INFER = 8'h00;
  localparam logic [7:0] FUNC_READ_MULTI = 8'h03;
  localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FUNC_WRITE_MULTI = 8'h10;

  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;

  // ==========================================================
  // register map
  localparam logic [15:0] INPUT_RESULT_FIRST = 16'h0001;
  localparam logic [15:0] ALIAS_WINDOW_FIRST = 16'h0065;
  localparam logic [15:0] OUTPUT_RESULT_FIRST = 16'h01f5;
  localparam logic [15:0] ALIAS_TABLE_FIRST = 16'h0259;
  localparam logic [15:0] BANK_ENTRIES = 16'h0010;
  localparam logic [15:0] PLC_OFFSET = 16'h9c40;

  // ==========================================================
  // limits
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_MAX = 16'h007d;
  localparam logic [7:0] SLAVE_ID_MIN = 8'h01;
  localparam logic [7:0] SLAVE_ID_MAX = 8'hf7;

  typedef logic [15:0][15:0] bank16_t;

endpackage

// >>> verilog/modbus_link_if.sv
// transaction link between the modbus host end and the register bank end
`timescale 1ns/100ps
`default_nettype none
interface modbus_link_if;
  logic req_valid;
  logic req_ready;
  logic [7:0] req_func;
  logic [15:0] req_addr;
  logic [15:0] req_count;
  logic wdata_valid;
  logic wdata_ready;
  logic [15:0] wdata;
  logic rdata_valid;
  logic [15:0] rdata;
  logic resp_valid;
  logic [7:0] resp_code;

  modport device_mp (
    input req_valid, req_func, req_addr, req_count, wdata_valid, wdata,
    output req_ready, wdata_ready, rdata_valid, rdata, resp_valid, resp_code
  );

  modport host_mp (
    output req_valid, req_func, req_addr, req_count, wdata_valid, wdata,
    input req_ready, wdata_ready, rdata_valid, rdata, resp_valid, resp_code
  );
endinterface
`default_nettype wire

// >>> verilog/modbus_bank_device.sv
// register bank end: input and output results, alias table and alias window
`timescale 1ns/100ps
`default_nettype none
module modbus_bank_device (
  input wire logic clk_i,
  input wire logic rstn_i,
  modbus_link_if.device_mp link,
  input wire logic modbus_mode_i,
  input wire logic [7:0] slave_id_i,
  input wire modbus_bank_pkg::bank16_t in_result_i,
  output logic [15:0][15:0] out_result_o
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_READ = 2'b01,
    DEV_WRITE = 2'b10,
    DEV_RESP = 2'b11
  } dev_phase_t;

  typedef struct packed {
    dev_phase_t phase;
    logic [15:0] addr;
    logic [15:0] count;
    logic [7:0] code;
    logic [15:0] rdata;
    logic rdata_valid;
    modbus_bank_pkg::bank16_t in_meta;
    modbus_bank_pkg::bank16_t in_sync;
    modbus_bank_pkg::bank16_t out_res;
    modbus_bank_pkg::bank16_t alias_tab;
  } dev_state_t;

  dev_state_t s;
  dev_state_t next_s;

  logic link_ok;
  logic [15:0] eff_addr;
  logic [15:0] read_word;
  logic start_readable;
  logic start_writable;

  // ==========================================================
  // address decode helpers
  function automatic logic in_region(input logic [15:0] a, input logic [15:0] first);
    logic [15:0] d;
    d = a - first;
    return (a >= first) && (d < modbus_bank_pkg::BANK_ENTRIES);
  endfunction

  function automatic logic [3:0] entry_of(input logic [15:0] a, input logic [15:0] first);
    logic [15:0] d;
    d = a - first;
    return d[3:0];
  endfunction

  function automatic logic func_known(input logic [7:0] f);
    return (f == modbus_bank_pkg::FUNC_READ_MULTI) ||
           (f == modbus_bank_pkg::FUNC_WRITE_SINGLE) ||
           (f == modbus_bank_pkg::FUNC_WRITE_MULTI);
  endfunction

  // ==========================================================
  // link gating
  // config inputs come from logic on this clock, so no synchroniser here
  assign link_ok = modbus_mode_i &&
                   (slave_id_i >= modbus_bank_pkg::SLAVE_ID_MIN) &&
                   (slave_id_i <= modbus_bank_pkg::SLAVE_ID_MAX); // [RULE6]

  assign link.req_ready = (s.phase == DEV_IDLE) && link_ok; // [RULE6]
  assign link.wdata_ready = (s.phase == DEV_WRITE);
  assign link.resp_valid = (s.phase == DEV_RESP);
  assign link.resp_code = s.code;
  assign link.rdata = s.rdata;
  assign link.rdata_valid = s.rdata_valid;
  assign out_result_o = s.out_res;

  // ==========================================================
  // alias resolution and read mux
  // a window entry that points back into the window reads zero, which
  // keeps resolution to one level and avoids any loop
  always_comb begin
    eff_addr = s.addr;
    read_word = 16'h0000;
    if (in_region(s.addr, modbus_bank_pkg::ALIAS_WINDOW_FIRST)) begin
      eff_addr = s.alias_tab[entry_of(s.addr, modbus_bank_pkg::ALIAS_WINDOW_FIRST)]; // [RULE10] [RULE12]
    end
    if (in_region(eff_addr, modbus_bank_pkg::INPUT_RESULT_FIRST)) begin
      read_word = s.in_sync[entry_of(eff_addr, modbus_bank_pkg::INPUT_RESULT_FIRST)]; // [RULE7]
    end else if (in_region(eff_addr, modbus_bank_pkg::OUTPUT_RESULT_FIRST)) begin
      read_word = s.out_res[entry_of(eff_addr, modbus_bank_pkg::OUTPUT_RESULT_FIRST)]; // [RULE8]
    end else if (in_region(eff_addr, modbus_bank_pkg::ALIAS_TABLE_FIRST)) begin
      read_word = s.alias_tab[entry_of(eff_addr, modbus_bank_pkg::ALIAS_TABLE_FIRST)]; // [RULE9]
    end
  end

  // only the start address is checked; a block that runs past a region
  // reads zero and drops writes in the gaps, runs on into any later region it reaches, and never fails halfway through
  always_comb begin
    start_readable = in_region(link.req_addr, modbus_bank_pkg::INPUT_RESULT_FIRST) ||
                     in_region(link.req_addr, modbus_bank_pkg::ALIAS_WINDOW_FIRST) ||
                     in_region(link.req_addr, modbus_bank_pkg::OUTPUT_RESULT_FIRST) ||
                     in_region(link.req_addr, modbus_bank_pkg::ALIAS_TABLE_FIRST);
    start_writable = in_region(link.req_addr, modbus_bank_pkg::ALIAS_WINDOW_FIRST) ||
                     in_region(link.req_addr, modbus_bank_pkg::OUTPUT_RESULT_FIRST) ||
                     in_region(link.req_addr, modbus_bank_pkg::ALIAS_TABLE_FIRST);
  end

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.rdata_valid = 1'b0;
    next_s.in_meta = in_result_i;
    next_s.in_sync = s.in_meta;
    unique case (s.phase)
      DEV_IDLE: begin
        if (link.req_valid && link.req_ready) begin
          next_s.addr = link.req_addr;
          next_s.count = link.req_count;
          if (link.req_func == modbus_bank_pkg::FUNC_WRITE_SINGLE) begin
            next_s.count = modbus_bank_pkg::COUNT_ONE; // [RULE3]
          end
          if (!func_known(link.req_func)) begin
            next_s.code = modbus_bank_pkg::EXC_FUNC; // [RULE1]
            next_s.phase = DEV_RESP;
          end else if ((link.req_func != modbus_bank_pkg::FUNC_WRITE_SINGLE) &&
                       ((link.req_count == 16'h0000) ||
                        (link.req_count > modbus_bank_pkg::COUNT_MAX))) begin
            next_s.code = modbus_bank_pkg::EXC_VALUE;
            next_s.phase = DEV_RESP;
          end else if (link.req_func == modbus_bank_pkg::FUNC_READ_MULTI) begin
            if (start_readable) begin
              next_s.code = modbus_bank_pkg::EXC_NONE;
              next_s.phase = DEV_READ; // [RULE2]
            end else begin
              next_s.code = modbus_bank_pkg::EXC_ADDR;
              next_s.phase = DEV_RESP;
            end
          end else begin
            if (start_writable) begin
              next_s.code = modbus_bank_pkg::EXC_NONE;
              next_s.phase = DEV_WRITE; // [RULE3] [RULE4]
            end else begin
              next_s.code = modbus_bank_pkg::EXC_ADDR;
              next_s.phase = DEV_RESP;
            end
          end
        end
      end
      DEV_READ: begin
        // one word per cycle, window entries resolved in table order
        next_s.rdata = read_word; // [RULE2] [RULE11]
        next_s.rdata_valid = 1'b1;
        next_s.addr = s.addr + modbus_bank_pkg::COUNT_ONE; // [RULE11]
        next_s.count = s.count - modbus_bank_pkg::COUNT_ONE;
        if (s.count == modbus_bank_pkg::COUNT_ONE) begin
          next_s.phase = DEV_RESP;
        end
      end
      DEV_WRITE: begin
        if (link.wdata_valid) begin
          // input results are read only; writes landing there are dropped
          if (in_region(eff_addr, modbus_bank_pkg::OUTPUT_RESULT_FIRST)) begin
            next_s.out_res[entry_of(eff_addr, modbus_bank_pkg::OUTPUT_RESULT_FIRST)] = link.wdata; // [RULE8] [RULE12]
          end else if (in_region(eff_addr, modbus_bank_pkg::ALIAS_TABLE_FIRST)) begin
            next_s.alias_tab[entry_of(eff_addr, modbus_bank_pkg::ALIAS_TABLE_FIRST)] = link.wdata; // [RULE9] [RULE12]
          end
          next_s.addr = s.addr + modbus_bank_pkg::COUNT_ONE; // [RULE4]
          next_s.count = s.count - modbus_bank_pkg::COUNT_ONE;
          if (s.count == modbus_bank_pkg::COUNT_ONE) begin
            next_s.phase = DEV_RESP;
          end
        end
      end
      DEV_RESP: begin
        next_s.phase = DEV_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// >>> verilog/modbus_bank_host.sv
// host end: turns user commands into link requests and collects answers
`timescale 1ns/100ps
`default_nettype none
module modbus_bank_host (
  input wire logic clk_i,
  input wire logic rstn_i,
  modbus_link_if.host_mp link,
  input wire logic net_ready_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [7:0] cmd_func_i,
  input wire logic [15:0] cmd_addr_i,
  input wire logic [15:0] cmd_count_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [15:0] wr_data_i,
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  output logic done_o,
  output logic [7:0] status_o
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_ISSUE = 2'b01,
    HOST_XFER = 2'b10
  } host_phase_t;

  typedef struct packed {
    host_phase_t phase;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] count;
    logic [15:0] wleft;
    logic [15:0] wbuf;
    logic wvalid;
    logic [15:0] rd_data;
    logic rd_valid;
    logic done;
    logic [7:0] status;
  } host_state_t;

  host_state_t s;
  host_state_t next_s;
  logic [7:0] func_m;
  logic [15:0] addr_m;
  logic is_write;

  // ==========================================================
  // command mapping
  always_comb begin
    func_m = cmd_func_i;
    addr_m = cmd_addr_i;
    if ((cmd_func_i == modbus_bank_pkg::FUNC_INFER) && (cmd_addr_i >= modbus_bank_pkg::PLC_OFFSET)) begin
      func_m = modbus_bank_pkg::FUNC_READ_MULTI; // [RULE5]
      addr_m = cmd_addr_i - modbus_bank_pkg::PLC_OFFSET; // [RULE5]
    end
  end

  assign is_write = (s.func != modbus_bank_pkg::FUNC_READ_MULTI);
  assign cmd_ready_o = (s.phase == HOST_IDLE) && net_ready_i; // [RULE6]
  // one word in flight; halves write throughput but keeps wdata on a flop
  assign wr_ready_o = (s.phase == HOST_XFER) && is_write && !s.wvalid && (s.wleft != 16'h0000);
  assign link.req_valid = (s.phase == HOST_ISSUE);
  assign link.req_func = s.func;
  assign link.req_addr = s.addr;
  assign link.req_count = s.count;
  assign link.wdata_valid = s.wvalid;
  assign link.wdata = s.wbuf;
  assign rd_valid_o = s.rd_valid;
  assign rd_data_o = s.rd_data;
  assign done_o = s.done;
  assign status_o = s.status;

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.rd_valid = 1'b0;
    unique case (s.phase)
      HOST_IDLE: begin
        if (cmd_valid_i && cmd_ready_o) begin
          if ((func_m == modbus_bank_pkg::FUNC_READ_MULTI) ||
              (func_m == modbus_bank_pkg::FUNC_WRITE_SINGLE) ||
              (func_m == modbus_bank_pkg::FUNC_WRITE_MULTI)) begin
            next_s.func = func_m; // [RULE1]
            next_s.addr = addr_m; // [RULE2] [RULE3] [RULE4]
            next_s.count = cmd_count_i;
            next_s.wleft = cmd_count_i;
            if (func_m == modbus_bank_pkg::FUNC_WRITE_SINGLE) begin
              next_s.count = modbus_bank_pkg::COUNT_ONE; // [RULE3]
              next_s.wleft = modbus_bank_pkg::COUNT_ONE;
            end
            next_s.phase = HOST_ISSUE;
          end else begin
            next_s.done = 1'b1; // [RULE1]
            next_s.status = modbus_bank_pkg::EXC_FUNC;
          end
        end
      end
      HOST_ISSUE: begin
        if (link.req_ready) begin
          next_s.phase = HOST_XFER;
        end
      end
      HOST_XFER: begin
        if (s.wvalid && link.wdata_ready) begin
          next_s.wvalid = 1'b0;
        end
        if (wr_valid_i && wr_ready_o) begin
          next_s.wbuf = wr_data_i; // [RULE4]
          next_s.wvalid = 1'b1;
          next_s.wleft = s.wleft - modbus_bank_pkg::COUNT_ONE;
        end
        if (link.rdata_valid) begin
          next_s.rd_data = link.rdata; // [RULE2]
          next_s.rd_valid = 1'b1;
        end
        if (link.resp_valid) begin
          next_s.done = 1'b1;
          next_s.status = link.resp_code;
          next_s.wvalid = 1'b0;
          next_s.phase = HOST_IDLE;
        end
      end
      default: begin
        next_s.phase = HOST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// >>> tb/modbus_bank_chk.sv
// assertions on the link between the host end and the register bank end
`timescale 1ns/100ps
`default_nettype none
module modbus_bank_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic modbus_mode_i,
  input wire logic [7:0] slave_id_i,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_count,
  input wire logic wdata_valid,
  input wire logic wdata_ready,
  input wire logic rdata_valid,
  input wire logic resp_valid,
  input wire logic [7:0] resp_code
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic taken;
  logic rd_req;
  assign taken = req_valid && req_ready;
  assign rd_req = taken && req_func == modbus_bank_pkg::FUNC_READ_MULTI;
  // ==========================================================
  // link assertions
  a_func_legal: assert property (req_valid |-> req_func inside {8'h03, 8'h06, 8'h10})
    else $error("link request carries an unsupported function code");
  a_read_first_word: assert property (rd_req && req_addr inside {[16'h0001:16'h0010]} &&
    req_count inside {[16'h0001:16'h007d]} |=> !rdata_valid ##1 rdata_valid)
    else $error("first read word not two cycles after the request");
  a_window_one_word: assert property (rd_req && req_addr inside {[16'h0065:16'h0074]} &&
    req_count == 16'h0001 |-> ##2 rdata_valid && resp_valid && resp_code == modbus_bank_pkg::EXC_NONE)
    else $error("single window read not answered with its word");
  a_count_zero: assert property (rd_req && req_count == 16'h0000 |=>
    resp_valid && resp_code == modbus_bank_pkg::EXC_VALUE)
    else $error("empty read not refused at once");
  a_single_write: assert property (taken && req_func == modbus_bank_pkg::FUNC_WRITE_SINGLE &&
    req_addr inside {[16'h01f5:16'h0204]} |=> wdata_ready)
    else $error("single write does not ask for its word");
  a_single_done: assert property (wdata_valid && wdata_ready &&
    req_func == modbus_bank_pkg::FUNC_WRITE_SINGLE |=> resp_valid && resp_code == modbus_bank_pkg::EXC_NONE)
    else $error("single write not answered after its word");
  a_write_no_early: assert property (wdata_ready |-> !resp_valid && !rdata_valid)
    else $error("answer given while write words are still due");
  a_serve_gate: assert property (req_ready |-> modbus_mode_i && slave_id_i >= 8'h01 && slave_id_i <= 8'hf7)
    else $error("device ready while not reachable");
  a_busy_refuse: assert property (taken |=> !req_ready)
    else $error("second request accepted during a transaction");
  a_resp_pulse: assert property (resp_valid |=> !resp_valid)
    else $error("answer strobe longer than one cycle");
  c_read: cover property (rd_req);
  c_write_multi: cover property (taken && req_func == modbus_bank_pkg::FUNC_WRITE_MULTI);
  c_error: cover property (resp_valid && resp_code != modbus_bank_pkg::EXC_NONE);
endmodule
`default_nettype wire

// >>> tb/modbus_io_register_aliasing_test.sv
// self-checking bench joining the host end and the register bank end
`timescale 1ns/100ps
`default_nettype none
module modbus_io_register_aliasing_test;
  logic clk, rstn, mode, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, done;
  logic [7:0] sid, func, status;
  logic [15:0] addr, count, wr_data, rd_data;
  logic [15:0][15:0] outr;
  logic [31:0] seed, r;
  modbus_bank_pkg::bank16_t inr;
  int err_total, num_checks, inp[16], outm[16], tab[16];
  int wq[$], eq[$];
  modbus_link_if link();
  modbus_bank_device modbus_bank_device_i (.clk_i(clk), .rstn_i(rstn), .link(link), .modbus_mode_i(mode),
    .slave_id_i(sid), .in_result_i(inr), .out_result_o(outr));
  modbus_bank_host modbus_bank_host_i (.clk_i(clk), .rstn_i(rstn), .link(link),
    .net_ready_i(mode && sid >= 8'h01 && sid <= 8'hf7), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_func_i(func), .cmd_addr_i(addr), .cmd_count_i(count), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready),
    .wr_data_i(wr_data), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .done_o(done), .status_o(status));
  modbus_bank_chk modbus_bank_chk_i (.clk_i(clk), .rstn_i(rstn), .modbus_mode_i(mode), .slave_id_i(sid),
    .req_valid(link.req_valid), .req_ready(link.req_ready), .req_func(link.req_func), .req_addr(link.req_addr),
    .req_count(link.req_count), .wdata_valid(link.wdata_valid), .wdata_ready(link.wdata_ready),
    .rdata_valid(link.rdata_valid), .resp_valid(link.resp_valid), .resp_code(link.resp_code));
  // ==========================================================
  // reference model of the bank
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int rd(int a);
    if (a >= 1 && a <= 16) return inp[a-1];
    if (a >= 501 && a <= 516) return outm[a-501];
    if (a >= 601 && a <= 616) return tab[a-601];
    // one level only: a window entry naming the window reads zero
    if (a >= 101 && a <= 116 && !(tab[a-101] >= 101 && tab[a-101] <= 116)) return rd(tab[a-101]);
    return 0;
  endfunction
  function automatic void wr(int a, int d);
    if (a >= 101 && a <= 116) a = tab[a-101];
    if (a >= 501 && a <= 516) outm[a-501] = d;
    else if (a >= 601 && a <= 616) tab[a-601] = d;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // one user command; error commands move no words
  task automatic cmd(input logic [7:0] f, input int a, input int n, input int st);
    int b;
    b = (f == 8'h00) ? a - 40000 : a;
    if (st == 0 && (f == 8'h03 || f == 8'h00))
      for (int k = 0; k < n; k++) eq.push_back(rd(b + k));
    @(negedge clk);
    func = f;
    addr = a[15:0];
    count = n[15:0];
    cmd_valid = 1'b1;
    #1;
    for (int i = 0; i < 200 && cmd_ready !== 1'b1; i++) begin
      @(negedge clk);
      #1;
    end
    chk(cmd_ready, 1'b1);
    @(negedge clk);
    cmd_valid = 1'b0;
    if (st == 0 && (f == 8'h06 || f == 8'h10)) begin
      wr_valid = 1'b1;
      for (int k = 0; k < n; k++) begin
        wr_data = 16'(wq.pop_front());
        #1;
        for (int i = 0; i < 200 && wr_ready !== 1'b1; i++) begin
          @(negedge clk);
          #1;
        end
        chk(wr_ready, 1'b1);
        wr(b + k, wr_data);
        @(negedge clk);
      end
      wr_valid = 1'b0;
    end
    for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge clk);
    // a wait that runs out must count, or a stale status would pass
    chk(done, 1'b1);
    chk(status, st);
  endtask
  always @(negedge clk) begin
    if (rd_valid === 1'b1) chk(rd_data, eq.size() > 0 ? eq.pop_front() : 32'h0001_0000);
  end
  // ==========================================================
  // stimulus
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    err_total++;
    final_report();
  end
  initial begin
    {rstn, cmd_valid, wr_valid, func, addr, count, wr_data} = '0;
    mode = 1'b1;
    sid = 8'h11;
    seed = 32'h5e00_4ab8;
    for (int k = 0; k < 16; k++) begin
      inp[k] = int'(xs() & 32'h0000_ffff);
      inr[k] = 16'(inp[k]);
    end
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    for (int k = 0; k < 16; k++) chk(outr[k], 0);
    wq = '{5, 7, 501, 2, 16, 9, 503, 102};
    cmd(8'h10, 601, 8, 0);
    for (int k = 0; k < 17; k++) wq.push_back(int'(xs() & 32'h0000_ffff));
    cmd(8'h10, 501, 16, 0);
    cmd(8'h06, 516, 1, 0);
    cmd(8'h03, 1, 16, 0);
    cmd(8'h03, 101, 16, 0);
    wq = '{16'h0a5c, 16'h3c3c, 16'h7e81};
    cmd(8'h06, 103, 1, 0);
    cmd(8'h10, 107, 2, 0);
    cmd(8'h03, 501, 16, 0);
    cmd(8'h03, 601, 16, 0);
    cmd(8'h00, 40501, 3, 0);
    cmd(8'h05, 1, 1, 1);
    cmd(8'h03, 1, 0, 3);
    cmd(8'h03, 1, 126, 3);
    cmd(8'h03, 300, 1, 2);
    cmd(8'h06, 1, 1, 2);
    for (int j = 0; j < 8; j++) begin
      r = xs();
      cmd(8'h03, 101 + int'(r % 8), 1 + int'((r >> 8) % 8), 0);
    end
    @(negedge clk);
    mode = 1'b0;
    #1;
    chk(link.req_ready, 0);
    chk(cmd_ready, 0);
    @(negedge clk);
    mode = 1'b1;
    sid = 8'h00;
    #1;
    chk(link.req_ready, 0);
    @(negedge clk);
    sid = 8'hf7;
    cmd(8'h03, 103, 1, 0);
    @(negedge clk);
    // words the device never returned would otherwise go unnoticed
    chk(eq.size(), 0);
    for (int k = 0; k < 16; k++) chk(outr[k], outm[k]);
    final_report();
  end
endmodule
`default_nettype wire
